// [logic/clk_mode_pkg.sv]
// clk_mode_pkg: constants, encodings and carrier types for the cpu clock
// mode controller; assumes nothing beyond a SystemVerilog-2012 tool.
package clk_mode_pkg;

  // divide field encodings (two-bit field, div8 overrides)
  localparam logic [1:0] DIV_FIELD_1  = 2'h0;
  localparam logic [1:0] DIV_FIELD_2  = 2'h1;
  localparam logic [1:0] DIV_FIELD_4  = 2'h2;
  localparam logic [1:0] DIV_FIELD_16 = 2'h3;

  // divider ratio codes driven out as a one-hot word
  localparam logic [4:0] RATIO_1  = 5'h01;
  localparam logic [4:0] RATIO_2  = 5'h02;
  localparam logic [4:0] RATIO_4  = 5'h04;
  localparam logic [4:0] RATIO_8  = 5'h08;
  localparam logic [4:0] RATIO_16 = 5'h10;

  // cpu clock source codes
  localparam logic [1:0] SRC_MAIN   = 2'h0;
  localparam logic [1:0] SRC_PLL    = 2'h1;
  localparam logic [1:0] SRC_ONCHIP = 2'h2;
  localparam logic [1:0] SRC_SUB    = 2'h3;

  // reset values of the control bits
  localparam logic RST_DIV8      = 1'h1;
  localparam logic RST_MAIN_STOP = 1'h0;
  localparam logic RST_SUB_EN    = 1'h0;
  localparam logic [1:0] RST_DIV = 2'h0;

  // timing: slowest main oscillator whose stop is guaranteed detected
  localparam int MIN_DETECT_FREQ_KHZ = 2000;
  localparam int SYS_CLK_KHZ         = 10000;
  // sys_clk cycles in one main clock period at the slowest rate (round down)
  localparam int DETECT_WINDOW_CYC   = SYS_CLK_KHZ / MIN_DETECT_FREQ_KHZ;
  // wait this many sys_clk cycles without a main edge before calling stop
  localparam int STOP_TIMEOUT_CYC    = 2 * DETECT_WINDOW_CYC + 1;

  // power states, one-hot
  typedef enum logic [2:0] {
    PWR_RUN  = 3'h1,
    PWR_WAIT = 3'h2,
    PWR_STOP = 3'h4
  } pwr_state_t;

  // one software write request to the clock controls
  typedef struct packed {
    logic       we_div8;
    logic       div8;
    logic       we_main_stop;
    logic       main_stop;
    logic       we_sub_en;
    logic       sub_en;
    logic       we_sys_sel;
    logic       sys_sel;
    logic       we_div;
    logic [1:0] div;
    logic       we_stop;
    logic       we_pll;
    logic       pll_en;
    logic       pll_sel;
    logic       we_onchip;
    logic       onchip;
    logic       we_wait_off;
    logic       wait_off;
    logic       we_det;
    logic       det_en;
    logic       resp_sel;
    logic       we_lock;
    logic       lock;
    logic       guard;
    logic       clr_flag;
  } clk_wr_t;

  // stored control state seen by software
  typedef struct packed {
    logic       div8;
    logic       main_stop;
    logic       sub_en;
    logic       sys_sel;
    logic [1:0] div;
    logic       pll_en;
    logic       pll_sel;
    logic       onchip;
    logic       wait_off;
    logic       det_en;
    logic       resp_sel;
    logic       lock;
    logic       det_flag;
    logic       main_stopped;
  } clk_stat_t;

endpackage : clk_mode_pkg

// [logic/cpu_clock_mode_control.sv]
// cpu_clock_mode_control: clock source, divider, low-power and oscillator
// stop detection logic; assumes main_osc_in is a slow level already in the
// sys_clk domain and that software writes arrive as one-cycle strobes.
//
// What this block does
// - spare oscillators may run as peripheral clock
// - pll mode entered and left via high-speed only
// - stop mode exit forces div8 to one
// - setting main stop forces div8 to one
// - sub clock select needs running sub oscillator
// - divider and sub enable change together only when div8 is forced
// - sub enable bit runs or stops sub oscillator
// - div8 wins, else field picks 1/2/4/16
// - system select one picks sub clock
// - main stop bit turns main oscillator off
// - on-chip select, else pll or main path
// - stop bit, wait command, interrupt releases
// - protect bit locks listed clock bits
// - detection enable monitors main stop and restart
// - response select picks reset or interrupt
// - detection guaranteed at two megahertz and up
// - interrupt stop on main moves cpu on-chip
// - stop detection sets flag and stopped status
`timescale 1ns/10ps
`default_nettype none
module cpu_clock_mode_control
  import clk_mode_pkg::*;
#(
  parameter int STOP_TIMEOUT = STOP_TIMEOUT_CYC  // cycles with no main edge
)(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire clk_wr_t    wr,             // software write strobes
  input  wire logic       wait_cmd,       // wait instruction executed
  input  wire logic       hw_irq,         // hardware interrupt pending
  input  wire logic       main_osc_in,    // sampled main oscillator
  input  wire logic       sub_osc_ok,     // sub oscillator running
  output clk_stat_t       stat,           // stored control state
  output logic [1:0]      cpu_src,        // selected cpu clock source
  output logic [4:0]      cpu_ratio,      // one-hot divider ratio
  output logic            main_osc_en,    // main oscillator enable
  output logic            sub_osc_en,     // sub oscillator enable
  output logic            onchip_osc_en,  // on-chip oscillator enable
  output logic            pll_on,         // pll enable out
  output logic            periph_onchip,  // peripherals run on-chip
  output logic            periph_gate,    // peripheral clock gated
  output logic            cpu_gate,       // cpu clock gated
  output logic            osc_stop_reset, // detection reset request
  output logic            osc_stop_irq    // detection interrupt request
);

  // control bits
  logic       div8_reg;
  logic       main_stop_reg;
  logic       sub_en_reg;
  logic       sys_sel_reg;
  logic [1:0] div_reg;
  logic       pll_en_reg;
  logic       pll_sel_reg;
  logic       onchip_reg;
  logic       wait_off_reg;
  logic       det_en_reg;
  logic       resp_sel_reg;
  logic       lock_reg;
  logic       guard_reg;
  logic       det_flag_reg;
  logic       stopped_reg;
  pwr_state_t pwr_reg;
  logic [15:0] idle_cnt_reg;   // cycles since last main edge
  logic        osc_prev_reg;   // previous main level for edge finding
  logic        rst_out_reg;
  logic        irq_reg;

  logic locked;        // protection active
  logic in_pll;        // currently in pll mode
  logic in_high;       // main path, no pll, no on-chip, no sub
  logic stop_exit;     // stop mode released this cycle
  logic main_edge;     // main oscillator toggled
  logic stop_evt;      // main stop detected
  logic restart_evt;   // main restart detected
  logic pll_req_ok;    // requested pll change is a legal transition
  logic div_ok;        // divider change allowed
  logic sub_ok;        // sub enable change allowed
  logic sys_ok;        // sub clock select allowed

  // lock gates writes only; hardware forcing of div8 and on-chip still acts
  assign locked = lock_reg;
  assign in_pll = pll_en_reg & pll_sel_reg;
  assign in_high = ~pll_sel_reg & ~onchip_reg & ~sys_sel_reg;

  // pll entry only from high-speed, exit only back to it
  assign pll_req_ok = (wr.pll_en & wr.pll_sel) ? in_high :
                      in_pll ? (~onchip_reg & ~sys_sel_reg) : 1'b1;
  // a divider write is refused while the same write changes sub enable
  assign div_ok = ~(wr.we_sub_en & (wr.sub_en != sub_en_reg));
  // only strobed divider fields count as a change; the rest are don't-care
  assign sub_ok = ~((wr.we_div & (wr.div != div_reg)) |
                    (wr.we_div8 & (wr.div8 != div8_reg)));
  // switching to sub clock only with a running sub oscillator; pll mode
  // may only go back to high speed, so the select is refused there
  assign sys_ok = (~wr.sys_sel | (sub_osc_ok & sub_en_reg) | sys_sel_reg) &
                  ~in_pll;

  assign stop_exit = (pwr_reg == PWR_STOP) & hw_irq;
  assign main_edge = main_osc_in ^ osc_prev_reg;
  // stop called after STOP_TIMEOUT quiet cycles; only trustworthy for main
  // clocks of 2 MHz and up, slower crystals may look stopped
  assign stop_evt = det_en_reg & ~stopped_reg &
                    (idle_cnt_reg >= 16'(STOP_TIMEOUT));
  assign restart_evt = det_en_reg & stopped_reg & main_edge;

  // div8 select: written by software, forced on stop exit and main stop
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      div8_reg <= RST_DIV8;
    end else if (stop_exit) begin
      div8_reg <= 1'b1;
    end else if (wr.we_main_stop & ~locked & wr.main_stop) begin
      div8_reg <= 1'b1;
    end else if (wr.we_div8 & div_ok) begin
      div8_reg <= wr.div8;
    end
  end

  // two-bit divide field; outside the protected set, so a locked part can
  // still trim its speed without giving up the source lock
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      div_reg <= RST_DIV;
    end else if (wr.we_div & div_ok) begin
      div_reg <= wr.div;
    end
  end

  // main oscillator stop bit, lockable
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      main_stop_reg <= RST_MAIN_STOP;
    end else if (wr.we_main_stop & ~locked) begin
      main_stop_reg <= wr.main_stop;
    end
  end

  // sub oscillator enable, never locked
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sub_en_reg <= RST_SUB_EN;
    end else if (wr.we_sub_en & sub_ok) begin
      sub_en_reg <= wr.sub_en;
    end
  end

  // system clock select, lockable and gated by sub oscillator state
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sys_sel_reg <= 1'b0;
    end else if (wr.we_sys_sel & ~locked & sys_ok) begin
      sys_sel_reg <= wr.sys_sel;
    end
  end

  // pll enable and path select, whole group lockable
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pll_en_reg  <= 1'b0;
      pll_sel_reg <= 1'b0;
    end else if (wr.we_pll & ~locked & pll_req_ok) begin
      pll_en_reg  <= wr.pll_en;
      pll_sel_reg <= wr.pll_sel;
    end
  end

  // on-chip select: hardware set on stop in interrupt response wins
  // pll mode leaves the select alone; the handler moves it itself
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      onchip_reg <= 1'b0;
    end else if (stop_evt & resp_sel_reg & ~sys_sel_reg & ~in_pll) begin
      onchip_reg <= 1'b1;
    end else if (wr.we_onchip & ~in_pll) begin
      onchip_reg <= wr.onchip;
    end
  end

  // peripheral clock in wait, lockable
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wait_off_reg <= 1'b0;
    end else if (wr.we_wait_off & ~locked) begin
      wait_off_reg <= wr.wait_off;
    end
  end

  // detection enable lockable; response select is not in the locked set
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      det_en_reg   <= 1'b0;
      resp_sel_reg <= 1'b0;
    end else if (wr.we_det) begin
      if (~locked) begin
        det_en_reg <= wr.det_en;
      end
      resp_sel_reg <= wr.resp_sel;
    end
  end

  // write guard and protect bit; protect only settable with guard open
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      guard_reg <= 1'b0;
      lock_reg  <= 1'b0;
    end else if (wr.we_lock) begin
      guard_reg <= wr.guard;
      if (guard_reg) begin
        lock_reg <= wr.lock;
      end
    end
  end

  // power state: stop by bit, wait by command, interrupt releases
  // both low-power entries are refused in pll mode
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pwr_reg <= PWR_RUN;
    end else begin
      case (pwr_reg)
        PWR_RUN: begin
          if (wr.we_stop & ~locked & ~in_pll) begin
            pwr_reg <= PWR_STOP;
          end else if (wait_cmd & ~in_pll) begin
            pwr_reg <= PWR_WAIT;
          end
        end
        PWR_WAIT, PWR_STOP: begin
          if (hw_irq) begin
            pwr_reg <= PWR_RUN;
          end
        end
        default: pwr_reg <= PWR_RUN;
      endcase
    end
  end

  // main oscillator watchdog: count cycles since the last edge
  // the count saturates, so a long stop never wraps into a fresh start
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      osc_prev_reg <= 1'b0;
      idle_cnt_reg <= 16'h0000;
    end else begin
      osc_prev_reg <= main_osc_in;
      if (main_edge | ~det_en_reg) begin
        idle_cnt_reg <= 16'h0000;
      end else if (idle_cnt_reg != 16'hFFFF) begin
        idle_cnt_reg <= idle_cnt_reg + 16'h0001;
      end
    end
  end

  // detection and stopped flags; hardware set wins over software clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      det_flag_reg <= 1'b0;
      stopped_reg  <= 1'b0;
    end else begin
      if (stop_evt | restart_evt) begin
        det_flag_reg <= 1'b1;
      end else if (wr.clr_flag) begin
        det_flag_reg <= 1'b0;
      end
      if (stop_evt) begin
        stopped_reg <= 1'b1;
      end else if (restart_evt) begin
        stopped_reg <= 1'b0;
      end
    end
  end

  // response: reset or interrupt, interrupt masked while flag stands
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rst_out_reg <= 1'b0;
      irq_reg     <= 1'b0;
    end else begin
      rst_out_reg <= (stop_evt | restart_evt) & ~resp_sel_reg;
      irq_reg     <= (stop_evt | restart_evt) & resp_sel_reg &
                     ~det_flag_reg;
    end
  end

  // cpu source and divider ratio decode
  always_comb begin
    if (sys_sel_reg) begin
      cpu_src = SRC_SUB;
    end else if (onchip_reg) begin
      cpu_src = SRC_ONCHIP;
    end else if (in_pll) begin
      cpu_src = SRC_PLL;
    end else begin
      cpu_src = SRC_MAIN;
    end
    if (div8_reg) begin
      cpu_ratio = RATIO_8;
    end else begin
      case (div_reg)
        DIV_FIELD_1:  cpu_ratio = RATIO_1;
        DIV_FIELD_2:  cpu_ratio = RATIO_2;
        DIV_FIELD_4:  cpu_ratio = RATIO_4;
        DIV_FIELD_16: cpu_ratio = RATIO_16;
        default:      cpu_ratio = RATIO_1;
      endcase
    end
  end

  // oscillator enables; stop mode halts main and pll
  assign main_osc_en   = ~main_stop_reg & (pwr_reg != PWR_STOP);
  assign sub_osc_en    = sub_en_reg;
  assign onchip_osc_en = onchip_reg | (stopped_reg & resp_sel_reg);
  assign pll_on        = pll_en_reg & (pwr_reg != PWR_STOP);
  // peripherals follow on-chip after a stop in interrupt response, even if cpu stays on sub
  assign periph_onchip = onchip_reg | (stopped_reg & resp_sel_reg);
  assign cpu_gate      = pwr_reg != PWR_RUN;
  assign periph_gate   = (pwr_reg == PWR_STOP) |
                         ((pwr_reg == PWR_WAIT) & wait_off_reg);
  assign osc_stop_reset = rst_out_reg;
  assign osc_stop_irq   = irq_reg;

  // status word
  assign stat = '{div8: div8_reg, main_stop: main_stop_reg,
                  sub_en: sub_en_reg, sys_sel: sys_sel_reg, div: div_reg,
                  pll_en: pll_en_reg, pll_sel: pll_sel_reg,
                  onchip: onchip_reg, wait_off: wait_off_reg,
                  det_en: det_en_reg, resp_sel: resp_sel_reg,
                  lock: lock_reg, det_flag: det_flag_reg,
                  main_stopped: stopped_reg};

endmodule : cpu_clock_mode_control
`default_nettype wire

// [sim/cpu_clock_mode_control_props.sv]
// cpu_clock_mode_control_props: port-level checks of the clock mode block
// assumes binding onto cpu_clock_mode_control, one sys_clk domain
`timescale 1ns/10ps
`default_nettype none
module cpu_clock_mode_control_props
  import clk_mode_pkg::*;
#(
  parameter int STOP_TIMEOUT = STOP_TIMEOUT_CYC  // quiet cycles to a stop
)(
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire clk_wr_t    wr,
  input wire logic       hw_irq,
  input wire logic       main_osc_in,
  input wire logic       sub_osc_ok,
  input wire clk_stat_t  stat,
  input wire logic [1:0] cpu_src,
  input wire logic [4:0] cpu_ratio,
  input wire logic       main_osc_en,
  input wire logic       sub_osc_en,
  input wire logic       cpu_gate,
  input wire logic       osc_stop_reset,
  input wire logic       osc_stop_irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [4:0] ratio_exp;  // ratio the stored bits ask for
  logic [1:0] src_exp;    // source the stored bits ask for
  logic [7:0] quiet_cnt;  // cycles of a still main clock while watched
  logic       osc_q;      // main level one cycle back
  logic       stop_q;     // stop state rebuilt from write strobes
  // div8 wins over the field; field 11 is /16, not /8
  always_comb begin
    ratio_exp = stat.div8 ? RATIO_8 :
      (stat.div == DIV_FIELD_16) ? RATIO_16 : 5'h01 << stat.div;
    src_exp = stat.sys_sel ? SRC_SUB : stat.onchip ? SRC_ONCHIP :
      (stat.pll_en && stat.pll_sel) ? SRC_PLL : SRC_MAIN;
  end
  // quiet count, cleared when monitoring is off so early calls show up
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      quiet_cnt <= 8'h00;
      osc_q     <= 1'b0;
    end else begin
      osc_q <= main_osc_in;
      if (!stat.det_en || main_osc_in != osc_q) begin
        quiet_cnt <= 8'h00;
      end else if (quiet_cnt != 8'hFF) begin
        quiet_cnt <= quiet_cnt + 8'h01;
      end
    end
  end
  // stop mode halts the main crystal, so the enable check needs the state
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stop_q <= 1'b0;
    end else if (stop_q && hw_irq) begin
      stop_q <= 1'b0;
    end else if (!cpu_gate && wr.we_stop && !stat.lock &&
                 !(stat.pll_en && stat.pll_sel)) begin
      stop_q <= 1'b1;
    end
  end
  sequence det_rst_s;
    $rose(stat.det_flag) && !stat.resp_sel;
  endsequence
  sequence det_irq_s;
    $rose(stat.det_flag) && stat.resp_sel;
  endsequence
  chk_ratio_map: assert property (cpu_ratio == ratio_exp)
    else $error("cpu ratio does not match divider bits");
  chk_src_map: assert property (cpu_src == src_exp)
    else $error("cpu source does not match select bits");
  chk_main_enable: assert property (main_osc_en ==
    (!stat.main_stop && !stop_q))
    else $error("main oscillator enable wrong");
  chk_sub_enable: assert property (sub_osc_en == stat.sub_en)
    else $error("sub oscillator enable wrong");
  chk_stop_div8: assert property (wr.we_main_stop && wr.main_stop &&
    !stat.lock |=> stat.div8 && stat.main_stop)
    else $error("main stop did not force div8");
  chk_lock_hold: assert property (stat.lock && (wr.we_sys_sel ||
    wr.we_main_stop) |=> $stable(stat.sys_sel) && $stable(stat.main_stop))
    else $error("locked bit changed");
  chk_sub_guard: assert property (wr.we_sys_sel && wr.sys_sel &&
    !stat.sys_sel && !(stat.sub_en && sub_osc_ok) |=> !stat.sys_sel)
    else $error("sub clock chosen while not running");
  chk_wake_irq: assert property (cpu_gate && hw_irq |=> !cpu_gate)
    else $error("interrupt did not release low power");
  chk_detect_time: assert property ($rose(stat.main_stopped) |->
    stat.det_flag && quiet_cnt == STOP_TIMEOUT + 1)
    else $error("stop flagged too early or too late");
  chk_reset_resp: assert property (det_rst_s |-> ##[0:1] osc_stop_reset)
    else $error("missing reset request on detection");
  chk_irq_resp: assert property (det_irq_s |-> ##[0:1] osc_stop_irq)
    else $error("missing interrupt request on detection");
endmodule : cpu_clock_mode_control_props
`default_nettype wire

// [sim/osc_model.sv]
// osc_model: main and sub oscillators feeding the clock mode block
// assumes enables from the block; main_fail stops the crystal on purpose
`timescale 1ns/10ps
`default_nettype none
module osc_model (
  input  wire logic sys_clk,
  input  wire logic main_en,
  input  wire logic sub_en,
  input  wire logic main_fail,
  output logic      main_osc,
  output logic      sub_ok
);
  logic       osc_q   = 1'b0;  // crystal level
  logic [2:0] sub_cnt = 3'h0;  // sub start-up time
  // 5 MHz toggle; a dead crystal just sits at its last level
  always @(posedge sys_clk) begin
    if (main_en && !main_fail) begin
      osc_q <= !osc_q;
    end
    sub_cnt <= !sub_en ? 3'h0 : (sub_cnt == 3'h7) ? sub_cnt : sub_cnt + 3'h1;
  end
  assign main_osc = osc_q;
  assign sub_ok   = (sub_cnt == 3'h7);  // slow start, not instant
endmodule : osc_model
`default_nettype wire

// [sim/test_cpu_clock_mode_control.sv]
// test_cpu_clock_mode_control: self-checking bench of the clock block
// assumes osc_model and the props checker compiled before this file
`timescale 1ns/10ps
`default_nettype none
module test_cpu_clock_mode_control
  import clk_mode_pkg::*;
;
  localparam int TMO = 3;  // short stop timeout keeps the run brief
  logic       sys_clk, rst, wait_cmd, hw_irq, main_fail;
  clk_wr_t    wr;
  clk_stat_t  stat;
  logic       main_osc_in, sub_osc_ok, main_osc_en, sub_osc_en, pll_on;
  logic [1:0] cpu_src;
  logic [4:0] cpu_ratio;
  logic       cpu_gate, osc_stop_reset, osc_stop_irq, periph_gate;
  logic       onchip_osc_en, periph_onchip;
  int         fail_count = 0;
  int         samples_checked = 0;
  // rows: div8, div field, expected one-hot ratio
  logic [7:0] rows [5] = '{8'h01, 8'h22, 8'h44, 8'h70, 8'h88};
  cpu_clock_mode_control #(.STOP_TIMEOUT(TMO)) cpu_clock_mode_control_i (
    .sys_clk(sys_clk), .rst(rst), .wr(wr), .wait_cmd(wait_cmd),
    .hw_irq(hw_irq), .main_osc_in(main_osc_in), .sub_osc_ok(sub_osc_ok),
    .stat(stat), .cpu_src(cpu_src), .cpu_ratio(cpu_ratio),
    .main_osc_en(main_osc_en), .sub_osc_en(sub_osc_en),
    .onchip_osc_en(onchip_osc_en), .pll_on(pll_on),
    .periph_onchip(periph_onchip), .periph_gate(periph_gate),
    .cpu_gate(cpu_gate), .osc_stop_reset(osc_stop_reset),
    .osc_stop_irq(osc_stop_irq));
  osc_model osc_model_i (.sys_clk(sys_clk), .main_en(main_osc_en),
    .sub_en(sub_osc_en), .main_fail(main_fail), .main_osc(main_osc_in),
    .sub_ok(sub_osc_ok));
  // compare and count
  task automatic chk(input string n, input logic [7:0] s, e);
    samples_checked++;
    if (s !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      fail_count++;
    end
  endtask : chk
  // one-cycle write strobe, launched and dropped at falling edges
  task automatic put(input clk_wr_t w);
    @(negedge sys_clk) wr = w;
    @(negedge sys_clk) wr = '0;
  endtask : put
  // guard, protect, guard clear
  task automatic lockset(input logic v);
    put('{we_lock:1, guard:1, lock:!v, default:0});
    put('{we_lock:1, guard:1, lock:v, default:0});
    put('{we_lock:1, lock:v, default:0});
  endtask : lockset
  // interrupt pulse wakes the cpu
  task automatic wake;
    @(negedge sys_clk) hw_irq = 1'b1;
    @(negedge sys_clk) hw_irq = 1'b0;
    chk("cpu_gate", cpu_gate, 0);
  endtask : wake
  // bounded wait for a one-cycle request pulse
  task automatic catch_pulse(input logic irq_side);
    repeat (40) begin
      @(negedge sys_clk);
      if ((irq_side ? osc_stop_irq : osc_stop_reset) === 1'b1) break;
    end
  endtask : catch_pulse
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // hang guard, far beyond the roughly 140 cycles the tests need
  initial begin
    repeat (5000) @(posedge sys_clk);
    fail_count++;
    end_sim;
  end
  initial begin
    {wait_cmd, hw_irq, main_fail} = 3'h0;
    wr  = '0;
    rst = 1'b1;
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk) rst = 1'b0;
    chk("ratio", cpu_ratio, RATIO_8);
    chk("src", cpu_src, SRC_MAIN);
    chk("main_en", main_osc_en, 1);
    $display("reset test done");
    foreach (rows[i]) begin
      put('{we_div8:1, div8:rows[i][7], we_div:1, div:rows[i][6:5],
            default:0});
      chk("ratio", cpu_ratio, {3'h0, rows[i][4:0]});
    end
    $display("divider table done");
    put('{we_div8:1, default:0});
    put('{we_main_stop:1, main_stop:1, default:0});
    chk("div8", stat.div8, 1);
    chk("main_en", main_osc_en, 0);
    put('{we_main_stop:1, default:0});
    $display("main stop test done");
    put('{we_sys_sel:1, sys_sel:1, default:0});
    chk("sys_sel", stat.sys_sel, 0);
    put('{we_sub_en:1, sub_en:1, we_div:1, div:2'h1, default:0});
    chk("div", stat.div, 0);
    put('{we_sub_en:1, sub_en:1, default:0});
    chk("sub_en", sub_osc_en, 1);
    repeat (20) if (!sub_osc_ok) @(negedge sys_clk);
    put('{we_sys_sel:1, sys_sel:1, default:0});
    chk("src", cpu_src, SRC_SUB);
    put('{we_sys_sel:1, default:0});
    put('{we_sub_en:1, default:0});
    chk("sub_en", sub_osc_en, 0);
    $display("sub clock test done");
    put('{we_pll:1, pll_en:1, pll_sel:1, default:0});
    chk("src", cpu_src, SRC_PLL);
    put('{we_onchip:1, onchip:1, default:0});
    chk("src", cpu_src, SRC_PLL);
    put('{we_pll:1, default:0});
    put('{we_onchip:1, onchip:1, default:0});
    chk("src", cpu_src, SRC_ONCHIP);
    put('{we_pll:1, pll_en:1, pll_sel:1, default:0});
    chk("pll_on", pll_on, 0);
    put('{we_div8:1, div8:1, default:0});
    put('{we_onchip:1, default:0});
    chk("src", cpu_src, SRC_MAIN);
    $display("pll test done");
    put('{we_div8:1, default:0});
    put('{we_stop:1, default:0});
    chk("cpu_gate", cpu_gate, 1);
    chk("periph_gate", periph_gate, 1);
    wake;
    chk("div8", stat.div8, 1);
    put('{we_wait_off:1, wait_off:1, default:0});
    @(negedge sys_clk) wait_cmd = 1'b1;
    @(negedge sys_clk) wait_cmd = 1'b0;
    chk("cpu_gate", cpu_gate, 1);
    chk("periph_gate", periph_gate, 1);
    wake;
    put('{we_wait_off:1, default:0});
    chk("periph_gate", periph_gate, 0);
    $display("low power test done");
    lockset(1'b1);
    chk("lock", stat.lock, 1);
    put('{we_main_stop:1, main_stop:1, default:0});
    chk("main_stop", stat.main_stop, 0);
    put('{we_div:1, div:2'h2, default:0});
    chk("div", stat.div, 2'h2);
    lockset(1'b0);
    chk("lock", stat.lock, 0);
    $display("lock test done");
    @(negedge sys_clk) main_fail = 1'b1;
    repeat (20) @(negedge sys_clk);
    chk("det_flag", stat.det_flag, 0);
    @(negedge sys_clk) main_fail = 1'b0;
    put('{we_det:1, det_en:1, default:0});
    @(negedge sys_clk) main_fail = 1'b1;
    catch_pulse(1'b0);
    chk("reset_req", osc_stop_reset, 1);
    chk("stopped", stat.main_stopped, 1);
    chk("det_flag", stat.det_flag, 1);
    main_fail = 1'b0;
    catch_pulse(1'b0);
    chk("reset_req", osc_stop_reset, 1);
    chk("stopped", stat.main_stopped, 0);
    put('{we_det:1, det_en:1, resp_sel:1, default:0});
    put('{clr_flag:1, default:0});
    @(negedge sys_clk) main_fail = 1'b1;
    catch_pulse(1'b1);
    chk("irq_req", osc_stop_irq, 1);
    @(negedge sys_clk);
    chk("src", cpu_src, SRC_ONCHIP);
    chk("onchip_en", onchip_osc_en, 1);
    chk("periph_on", periph_onchip, 1);
    $display("detection test done");
    end_sim;
  end
endmodule : test_cpu_clock_mode_control
bind cpu_clock_mode_control cpu_clock_mode_control_props #(
  .STOP_TIMEOUT(STOP_TIMEOUT)
) props_i (
  .sys_clk(sys_clk), .rst(rst), .wr(wr), .hw_irq(hw_irq),
  .main_osc_in(main_osc_in), .sub_osc_ok(sub_osc_ok), .stat(stat),
  .cpu_src(cpu_src), .cpu_ratio(cpu_ratio), .main_osc_en(main_osc_en),
  .sub_osc_en(sub_osc_en), .cpu_gate(cpu_gate),
  .osc_stop_reset(osc_stop_reset), .osc_stop_irq(osc_stop_irq));
`default_nettype wire
